// File: uefc_match_if.sv
// Interface carrying one received character to the pattern matcher.
// Assumes a single clock shared by both modules.
`timescale 1ns/1ps
interface uefc_match_if;
	logic rx_valid;
	logic [7:0] rx_char;
	logic [15:0] pattern;
	logic two_char;
	logic hit;
	modport ctrl (output rx_valid, output rx_char, output pattern,
		output two_char, input hit);
	modport matcher (input rx_valid, input rx_char, input pattern,
		input two_char, output hit);
endinterface

// File: uefc_matcher.sv
// Matches a one- or two-character pattern on the received stream.
// Assumes characters arrive as single-cycle valid strobes.
`timescale 1ns/1ps
module uefc_matcher (
	input wire logic pclk,
	input wire logic presetn,
	uefc_match_if.matcher m
);
	logic [7:0] prev_q;
	logic prev_ok_q;

	// Previous character remembered for two-character sequences
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 8'h00;
			prev_ok_q <= 1'b0;
		end else if (m.rx_valid) begin
			prev_q <= m.rx_char;
			prev_ok_q <= 1'b1;
		end
	end

	// Bit 0 of the pattern meets the character's LSB
	always_comb begin
		if (!m.rx_valid) begin
			m.hit = 1'b0;
		end else if (m.two_char) begin
			m.hit = prev_ok_q && prev_q == m.pattern[15:8] &&
				m.rx_char == m.pattern[7:0];
		end else begin
			m.hit = m.rx_char == m.pattern[7:0];
		end
	end
endmodule

// File: uefc_pkg.sv
// Package for the enhanced flow control block of one UART channel.
// Assumes a 32-bit APB register bus and one clock domain.
package uefc_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] UEFC_OFF_IER = 8'h04;
	localparam logic [7:0] UEFC_OFF_ISR = 8'h08;
	localparam logic [7:0] UEFC_OFF_FCR = 8'h0c;
	localparam logic [7:0] UEFC_OFF_LCR = 8'h10;
	localparam logic [7:0] UEFC_OFF_MCR = 8'h14;
	localparam logic [7:0] UEFC_OFF_LSR = 8'h18;
	localparam logic [7:0] UEFC_OFF_MSR = 8'h1c;
	localparam logic [7:0] UEFC_OFF_EFR = 8'h20;
	localparam logic [7:0] UEFC_OFF_FIRST_RESUME_CHAR = 8'h24;
	localparam logic [7:0] UEFC_OFF_SECOND_RESUME_CHAR = 8'h28;
	localparam logic [7:0] UEFC_OFF_FIRST_STOP_CHAR = 8'h2c;
	localparam logic [7:0] UEFC_OFF_SECOND_STOP_CHAR = 8'h30;
	localparam logic [7:0] UEFC_OFF_RXCH = 8'h34;
	// Reset values
	localparam logic [7:0] UEFC_RST_ZERO = 8'h00;
	localparam logic [7:0] UEFC_RST_ISR = 8'h01;
	localparam logic [7:0] UEFC_RST_LSR = 8'h60;
	// Field positions
	localparam int UEFC_EFR_SCD = 5;
	localparam int UEFC_EFR_ENH = 4;
	localparam int UEFC_ISR_SPC = 4;
	// Enhanced-bit masks guarded by the write-protect latch
	localparam logic [7:0] UEFC_ENH_IER = 8'hf0;
	localparam logic [7:0] UEFC_ENH_ISR = 8'h30;
	localparam logic [7:0] UEFC_ENH_FCR = 8'h30;
	localparam logic [7:0] UEFC_ENH_MCR = 8'he0;
	// Flow-control select codes
	typedef enum logic [1:0] {
		UEFC_FC_NONE = 2'b00,
		UEFC_FC_SECOND = 2'b01,
		UEFC_FC_FIRST = 2'b10,
		UEFC_FC_BOTH = 2'b11
	} uefc_fc_t;
endpackage

// File: uefc_station.sv
// Remote station model handing received characters to the block.
// Assumes one character per pclk strobe, sent when the bench asks.
`timescale 1ns/1ps
module uefc_station (
	input wire logic pclk,
	output logic rx_char_valid,
	output logic [7:0] rx_char_data
);
	// Idle line at time zero
	initial begin
		rx_char_valid = 1'b0;
		rx_char_data = 8'h00;
	end
	// Data inverted after the strobe so a stale byte never matches twice
	task automatic send(input logic [7:0] c);
		@(posedge pclk);
		rx_char_valid <= 1'b1;
		rx_char_data <= c;
		@(posedge pclk);
		rx_char_valid <= 1'b0;
		rx_char_data <= ~c;
	endtask
endmodule

// File: uefc_top.sv
// Enhanced feature, special character and software flow control.
// Assumes an APB master on pclk and line pins synchronised here.
// Operation
// - Detect second stop char, flag interrupt bit 4
// - Special detect off after reset
// - Pattern bit 0 compares character LSB
// - Enhanced bits writable only while enable set
// - Enhanced write enable resets to zero
// - Transmit select decodes none, first, second, both
// - Receive select decodes none, first, second
// - Receive select 11 compares both pairs
// - Reset clears the five control registers
// - Interrupt status resets to 01
// - Line status resets to 60
// - Modem status high nibble follows pins
// - Serial out, RTS, DTR high at reset
// - Receive ready high, transmit ready low
// - Paired registers form two-character patterns
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module uefc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char_data,
	input wire logic [3:0] modem_in_pins,
	input wire logic tx_send_req,
	output logic serial_out_ch_a,
	output logic request_to_send_ch_a,
	output logic terminal_ready_ch_a,
	output logic rx_ready_out,
	output logic tx_ready_out,
	output logic tx_suspended,
	output logic [1:0] tx_flow_mode,
	output logic tx_two_char
);
	import uefc_pkg::*;

	logic [7:0] ier_q, isr_q, fcr_q, lcr_q, mcr_q, lsr_q, msr_q;
	logic [7:0] efr_q, first_resume_char_q, second_resume_char_q, first_stop_char_q, second_stop_char_q, rxch_q;
	logic [3:0] pins_s1_q, pins_s2_q, pins_prev_q;
	logic wr, rd;
	logic isr_rd;
	logic msr_rd;
	logic susp_q;
	logic scd_hit, stop_hit, resume_hit;
	uefc_fc_t rx_sel, tx_sel;
	logic [15:0] stop_pat, resume_pat;
	logic rx_two;

	uefc_match_if scd_m ();
	uefc_match_if stop_m ();
	uefc_match_if res_m ();

	// APB strobes, always a zero-wait answer
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign isr_rd = rd && paddr == UEFC_OFF_ISR;
	assign msr_rd = rd && paddr == UEFC_OFF_MSR;

	// Write a register, keeping guarded bits when the latch is closed
	function automatic logic [7:0] guard(input logic [7:0] old,
		input logic [7:0] nw, input logic [7:0] mask, input logic en);
		if (en)
			return nw;
		return (old & mask) | (nw & ~mask);
	endfunction

	// Plain control registers, all zero after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcr_q <= UEFC_RST_ZERO;
			first_resume_char_q <= UEFC_RST_ZERO;
			second_resume_char_q <= UEFC_RST_ZERO;
			first_stop_char_q <= UEFC_RST_ZERO;
			second_stop_char_q <= UEFC_RST_ZERO;
			efr_q <= UEFC_RST_ZERO;
		end else if (wr) begin
			if (paddr == UEFC_OFF_LCR) begin
				lcr_q <= pwdata[7:0];
			end else if (paddr == UEFC_OFF_EFR) begin
				efr_q <= pwdata[7:0];
			end else if (paddr == UEFC_OFF_FIRST_RESUME_CHAR) begin
				first_resume_char_q <= pwdata[7:0];
			end else if (paddr == UEFC_OFF_SECOND_RESUME_CHAR) begin
				second_resume_char_q <= pwdata[7:0];
			end else if (paddr == UEFC_OFF_FIRST_STOP_CHAR) begin
				first_stop_char_q <= pwdata[7:0];
			end else if (paddr == UEFC_OFF_SECOND_STOP_CHAR) begin
				second_stop_char_q <= pwdata[7:0];
			end
		end
	end

	// Enhanced-bit holders; closing the latch freezes their upper fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ier_q <= UEFC_RST_ZERO;
			fcr_q <= UEFC_RST_ZERO;
			mcr_q <= UEFC_RST_ZERO;
		end else if (wr) begin
			if (paddr == UEFC_OFF_IER) begin
				ier_q <= guard(ier_q, pwdata[7:0], UEFC_ENH_IER,
					efr_q[UEFC_EFR_ENH]);
			end else if (paddr == UEFC_OFF_FCR) begin
				fcr_q <= guard(fcr_q, pwdata[7:0], UEFC_ENH_FCR,
					efr_q[UEFC_EFR_ENH]);
			end else if (paddr == UEFC_OFF_MCR) begin
				mcr_q <= guard(mcr_q, pwdata[7:0], UEFC_ENH_MCR,
					efr_q[UEFC_EFR_ENH]);
			end
		end
	end

	// Interrupt status: detect bit is sticky, cleared by reading,
	// but a hit in the read cycle wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isr_q <= UEFC_RST_ISR;
		end else begin
			if (scd_hit) begin
				isr_q[UEFC_ISR_SPC] <= 1'b1;
				isr_q[0] <= 1'b0;
			end else if (isr_rd) begin
				isr_q[UEFC_ISR_SPC] <= 1'b0;
				isr_q[0] <= 1'b1;
			end
			if (wr && paddr == UEFC_OFF_ISR && efr_q[UEFC_EFR_ENH]) begin
				isr_q[5] <= pwdata[5];
			end
		end
	end

	// Line status: data-ready follows received characters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lsr_q <= UEFC_RST_LSR;
			rxch_q <= UEFC_RST_ZERO;
		end else if (rx_char_valid) begin
			lsr_q[0] <= 1'b1;
			rxch_q <= rx_char_data;
		end else if (rd && paddr == UEFC_OFF_RXCH) begin
			lsr_q[0] <= 1'b0;
		end
	end

	// Modem pins cross two flops; no reset so status stays live in reset
	always_ff @(posedge pclk) begin
		pins_s1_q <= modem_in_pins;
		pins_s2_q <= pins_s1_q;
		pins_prev_q <= pins_s2_q;
	end

	// Modem status: live upper nibble, sticky deltas cleared on read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msr_q <= UEFC_RST_ZERO;
		end else begin
			msr_q[7:4] <= pins_s2_q;
			msr_q[3:0] <= (msr_rd ? 4'h0 : msr_q[3:0]) |
				(pins_s2_q ^ pins_prev_q);
		end
	end

	// Flow select decode; software keeps detect and selects exclusive
	assign tx_sel = uefc_fc_t'(efr_q[3:2]);
	assign rx_sel = uefc_fc_t'(efr_q[1:0]);
	assign tx_flow_mode = tx_sel;
	assign tx_two_char = tx_sel == UEFC_FC_BOTH;
	assign rx_two = rx_sel == UEFC_FC_BOTH;

	// Pick the stop and resume patterns for the receiver
	always_comb begin
		case (rx_sel)
			UEFC_FC_FIRST: begin
				stop_pat = {8'h00, first_stop_char_q};
				resume_pat = {8'h00, first_resume_char_q};
			end
			UEFC_FC_SECOND: begin
				stop_pat = {8'h00, second_stop_char_q};
				resume_pat = {8'h00, second_resume_char_q};
			end
			UEFC_FC_BOTH: begin
				stop_pat = {first_stop_char_q, second_stop_char_q};
				resume_pat = {first_resume_char_q, second_resume_char_q};
			end
			default: begin
				stop_pat = 16'h0000;
				resume_pat = 16'h0000;
			end
		endcase
	end

	// Matchers: special detect, stop and resume
	assign scd_m.rx_valid = rx_char_valid && efr_q[UEFC_EFR_SCD];
	assign scd_m.rx_char = rx_char_data;
	assign scd_m.pattern = {8'h00, second_stop_char_q};
	assign scd_m.two_char = 1'b0;
	assign scd_hit = scd_m.hit;
	assign stop_m.rx_valid = rx_char_valid && rx_sel != UEFC_FC_NONE;
	assign stop_m.rx_char = rx_char_data;
	assign stop_m.pattern = stop_pat;
	assign stop_m.two_char = rx_two;
	assign stop_hit = stop_m.hit;
	assign res_m.rx_valid = rx_char_valid && rx_sel != UEFC_FC_NONE;
	assign res_m.rx_char = rx_char_data;
	assign res_m.pattern = resume_pat;
	assign res_m.two_char = rx_two;
	assign resume_hit = res_m.hit;

	uefc_matcher u_scd (.pclk(pclk), .presetn(presetn), .m(scd_m));
	uefc_matcher u_stop (.pclk(pclk), .presetn(presetn), .m(stop_m));
	uefc_matcher u_res (.pclk(pclk), .presetn(presetn), .m(res_m));

	// Transmit suspension; cleared when flow control is turned off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			susp_q <= 1'b0;
		end else if (rx_sel == UEFC_FC_NONE) begin
			susp_q <= 1'b0;
		end else if (stop_hit) begin
			susp_q <= 1'b1;
		end else if (resume_hit) begin
			susp_q <= 1'b0;
		end
	end
	assign tx_suspended = susp_q;

	// Pin outputs; serial line idles high, no serialiser here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_ch_a <= 1'b1;
			request_to_send_ch_a <= 1'b1;
			terminal_ready_ch_a <= 1'b1;
			rx_ready_out <= 1'b1;
			tx_ready_out <= 1'b0;
		end else begin
			serial_out_ch_a <= 1'b1;
			request_to_send_ch_a <= ~mcr_q[1];
			terminal_ready_ch_a <= ~mcr_q[0];
			rx_ready_out <= ~lsr_q[0];
			tx_ready_out <= susp_q | ~tx_send_req;
		end
	end

	// Read mux; unmapped addresses read zero with an error
	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == UEFC_OFF_IER) begin
			prdata[7:0] = ier_q;
		end else if (paddr == UEFC_OFF_ISR) begin
			prdata[7:0] = isr_q;
		end else if (paddr == UEFC_OFF_FCR) begin
			prdata[7:0] = fcr_q;
		end else if (paddr == UEFC_OFF_LCR) begin
			prdata[7:0] = lcr_q;
		end else if (paddr == UEFC_OFF_MCR) begin
			prdata[7:0] = mcr_q;
		end else if (paddr == UEFC_OFF_LSR) begin
			prdata[7:0] = lsr_q;
		end else if (paddr == UEFC_OFF_MSR) begin
			prdata[7:0] = {pins_s2_q, msr_q[3:0]};
		end else if (paddr == UEFC_OFF_EFR) begin
			prdata[7:0] = efr_q;
		end else if (paddr == UEFC_OFF_FIRST_RESUME_CHAR) begin
			prdata[7:0] = first_resume_char_q;
		end else if (paddr == UEFC_OFF_SECOND_RESUME_CHAR) begin
			prdata[7:0] = second_resume_char_q;
		end else if (paddr == UEFC_OFF_FIRST_STOP_CHAR) begin
			prdata[7:0] = first_stop_char_q;
		end else if (paddr == UEFC_OFF_SECOND_STOP_CHAR) begin
			prdata[7:0] = second_stop_char_q;
		end else if (paddr == UEFC_OFF_RXCH) begin
			prdata[7:0] = rxch_q;
		end else begin
			pslverr = psel && penable;
		end
	end
endmodule

// File: uefc_top_properties.sv
// Concurrent checks on the enhanced flow control top ports.
// Assumes one pclk domain; bound to every uefc_top below.
`timescale 1ns/1ps
module uefc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic rx_char_valid,
	input wire logic [3:0] modem_in_pins,
	input wire logic serial_out_ch_a,
	input wire logic request_to_send_ch_a,
	input wire logic terminal_ready_ch_a,
	input wire logic rx_ready_out,
	input wire logic tx_ready_out,
	input wire logic tx_suspended,
	input wire logic [1:0] tx_flow_mode,
	input wire logic tx_two_char
);
	import uefc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_efr;
	logic rd_msr;
	logic [1:0] fm_q;
	// Access phase decode
	assign wr_efr = psel && penable && pwrite && paddr == UEFC_OFF_EFR;
	assign rd_msr = psel && penable && !pwrite && paddr == UEFC_OFF_MSR;
	// Shadow of the transmit select, kept apart from the design's copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fm_q <= 2'b00;
		end else if (wr_efr) begin
			fm_q <= pwdata[3:2];
		end
	end
	a_txd_idle_high: assert property (serial_out_ch_a)
		else $error("serial out not high");
	a_reset_out_state: assert property ($rose(presetn) |->
		request_to_send_ch_a && terminal_ready_ch_a && rx_ready_out
		&& !tx_ready_out) else $error("outputs wrong after reset");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h34
		|-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	a_mapped_ok: assert property (psel && penable
		&& paddr == UEFC_OFF_EFR |-> !pslverr)
		else $error("enhanced control refused");
	a_tx_mode_mirror: assert property (wr_efr |=>
		tx_flow_mode == fm_q && tx_two_char == &fm_q)
		else $error("tx select decode wrong");
	a_suspend_ready: assert property (tx_suspended |=> tx_ready_out)
		else $error("tx ready low while suspended");
	a_rx_ready_out_drop: assert property (rx_char_valid |-> ##2 !rx_ready_out)
		else $error("rx ready did not fall");
	a_modem_follow: assert property (
		$stable(modem_in_pins) [*4] ##0 rd_msr |->
		prdata[7:4] == modem_in_pins) else $error("modem nibble stale");
	c_suspend: cover property (tx_suspended);
	c_refuse: cover property (pslverr);
	c_rx_wait: cover property (rx_char_valid ##2 !rx_ready_out);
endmodule
bind uefc_top uefc_checker chk (.*);

// File: uefc_top_tb.sv
// Self-checking bench for the enhanced flow control block.
// Assumes the station model and the bound checker beside it.
`timescale 1ns/1ps
module uefc_top_tb;
	import uefc_pkg::*;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic er;
	} uefc_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] modem_in_pins = 4'h0;
	logic tx_send_req = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic [1:0] tx_flow_mode;
	logic pready, pslverr, serial_out_ch_a, request_to_send_ch_a, rerr;
	logic terminal_ready_ch_a, rx_ready_out, tx_ready_out, tx_suspended;
	logic rx_char_valid, tx_two_char;
	logic [7:0] rx_char_data;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	uefc_row_t rows [19] = '{
		'{1'b0, UEFC_OFF_IER, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_ISR, 8'h00, 8'h01, 1'b0},
		'{1'b0, UEFC_OFF_LCR, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_MCR, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_LSR, 8'h00, 8'h60, 1'b0},
		'{1'b0, UEFC_OFF_EFR, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_FCR, 8'h00, 8'h00, 1'b0},
		'{1'b1, UEFC_OFF_EFR, 8'h10, 8'h00, 1'b0},
		'{1'b1, UEFC_OFF_IER, 8'hff, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_IER, 8'h00, 8'hff, 1'b0},
		'{1'b1, UEFC_OFF_MCR, 8'he3, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_MCR, 8'h00, 8'he3, 1'b0},
		'{1'b1, UEFC_OFF_EFR, 8'h00, 8'h00, 1'b0},
		'{1'b1, UEFC_OFF_IER, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_IER, 8'h00, 8'hf0, 1'b0},
		'{1'b1, UEFC_OFF_MCR, 8'h00, 8'h00, 1'b0},
		'{1'b0, UEFC_OFF_MCR, 8'h00, 8'he0, 1'b0},
		'{1'b0, 8'h3c, 8'h00, 8'h00, 1'b1},
		'{1'b1, 8'h3c, 8'hff, 8'h00, 1'b1}};
	uefc_top dut (.*);
	uefc_station st (.*);
	// Free-running 50 MHz clock
	initial forever #10 pclk = ~pclk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("BAD timeout expected finish seen hang");
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; request held until pready is seen high, for at most 40 cycles
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk("read data", {24'h0, e}, rdat);
	endtask
	task automatic run_rows(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (rows[i].w === 1'b0) chk("row data", 32'(rows[i].e), rdat);
			chk("row slverr", {31'h0, rows[i].er}, {31'h0, rerr});
		end
		$display("rows %0d to %0d done", lo, hi);
	endtask
	// Suspend only shows on tx_ready_out one edge after the flop
	task automatic step(input logic [7:0] c, input logic e);
		st.send(c);
		repeat (2) @(posedge pclk);
		#1;
		chk("suspend", {31'h0, e}, {31'h0, tx_suspended});
		chk("tx ready", {31'h0, e}, {31'h0, tx_ready_out});
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		run_rows(0, 18);
		// Every transmit code, receive select held at 11
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, UEFC_OFF_EFR, {4'h0, 2'(m), 2'b11});
			#1;
			chk("tx mode", 32'(m), {30'h0, tx_flow_mode});
			chk("two char", 32'(m == 3), {31'h0, tx_two_char});
		end
		$display("tx select test done");
		apb(1'b1, UEFC_OFF_SECOND_STOP_CHAR, 8'h81);
		apb(1'b1, UEFC_OFF_EFR, 8'h00);
		st.send(8'h81);
		rd(UEFC_OFF_ISR, 8'h01);
		apb(1'b1, UEFC_OFF_EFR, 8'h20);
		st.send(8'h80);
		rd(UEFC_OFF_ISR, 8'h01);
		st.send(8'h01);
		rd(UEFC_OFF_ISR, 8'h01);
		st.send(8'h81);
		rd(UEFC_OFF_ISR, 8'h10);
		rd(UEFC_OFF_RXCH, 8'h81);
		rd(UEFC_OFF_ISR, 8'h01);
		$display("special char test done");
		apb(1'b1, UEFC_OFF_FIRST_RESUME_CHAR, 8'h11);
		apb(1'b1, UEFC_OFF_SECOND_RESUME_CHAR, 8'h22);
		apb(1'b1, UEFC_OFF_FIRST_STOP_CHAR, 8'h13);
		apb(1'b1, UEFC_OFF_SECOND_STOP_CHAR, 8'h23);
		tx_send_req <= 1'b1;
		apb(1'b1, UEFC_OFF_EFR, 8'h02);
		step(8'h23, 1'b0);
		step(8'h13, 1'b1);
		step(8'h11, 1'b0);
		apb(1'b1, UEFC_OFF_EFR, 8'h01);
		step(8'h13, 1'b0);
		step(8'h23, 1'b1);
		step(8'h22, 1'b0);
		apb(1'b1, UEFC_OFF_EFR, 8'h03);
		step(8'h13, 1'b0);
		step(8'h23, 1'b1);
		step(8'h11, 1'b1);
		step(8'h22, 1'b0);
		$display("flow control test done");
		modem_in_pins <= 4'ha;
		apb(1'b1, UEFC_OFF_MCR, 8'h03);
		apb(1'b1, UEFC_OFF_EFR, 8'h13);
		repeat (2) @(posedge pclk);
		#1;
		chk("pins run", 32'h10, {27'h0, serial_out_ch_a, request_to_send_ch_a,
			terminal_ready_ch_a, rx_ready_out, tx_ready_out});
		apb(1'b0, UEFC_OFF_MSR, 8'h00);
		chk("msr pins", 32'ha, {28'h0, rdat[7:4]});
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk("pins reset", 32'h1e, {27'h0, serial_out_ch_a, request_to_send_ch_a,
			terminal_ready_ch_a, rx_ready_out, tx_ready_out});
		repeat (11) @(posedge pclk);
		presetn <= 1'b1;
		run_rows(0, 6);
		apb(1'b0, UEFC_OFF_MSR, 8'h00);
		chk("msr after reset", 32'ha, {28'h0, rdat[7:4]});
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule
